// ---- core/rwsup_pkg.sv ----
package rwsup_pkg;

   // System clock rate and power-on delay.
   localparam int unsigned SYS_CLK_HZ = 20_000_000;
   localparam int unsigned POR_DELAY_US = 100;
   localparam int unsigned POR_DELAY_CYC = POR_DELAY_US * (SYS_CLK_HZ / 1_000_000);
   localparam int unsigned POR_CNT_W = 12;
   localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_DELAY_CYC - 1);

   // Watchdog timing in RC oscillator cycles.
   localparam int unsigned WD_CNT_W = 21;
   localparam int unsigned WD_EXP_0 = 12;
   localparam int unsigned WD_EXP_1 = 15;
   localparam int unsigned WD_EXP_2 = 18;
   localparam int unsigned WD_EXP_3 = 21;
   localparam int unsigned WD_GRACE_RC = 512;
   localparam int unsigned WD_RST_RC = 8;
   localparam logic [WD_CNT_W-1:0] WD_GRACE_LAST = WD_CNT_W'(WD_GRACE_RC - 1);
   localparam logic [WD_CNT_W-1:0] WD_RST_LAST = WD_CNT_W'(WD_RST_RC - 1);

   // Least low time of the external reset pin in system clock cycles.
   localparam int unsigned EXT_MIN_SYS = 4;
   localparam logic [2:0] EXT_LAST = 3'(EXT_MIN_SYS - 1);

   // Address where execution starts after any reset.
   localparam logic [15:0] RESET_VECTOR = 16'h8000;

   // Register byte offsets.
   localparam logic [11:0] OFF_WD_CTRL = 12'h000;
   localparam logic [11:0] OFF_WD_RESTART = 12'h004;
   localparam logic [11:0] OFF_WD_STATUS = 12'h008;
   localparam logic [11:0] OFF_SYS_CTRL = 12'h00C;
   localparam logic [11:0] OFF_DEBUG_FLAGS = 12'h010;
   localparam logic [11:0] OFF_RESET_CAUSE = 12'h014;
   localparam logic [11:0] OFF_BO_CTRL = 12'h018;
   localparam logic [11:0] OFF_BO_STATUS = 12'h01C;

   // Field positions.
   localparam int unsigned WDC_EN_BIT = 0;
   localparam int unsigned WDC_SEL_LSB = 1;
   localparam int unsigned WDS_IRQ_BIT = 0;
   localparam int unsigned WDS_GRACE_BIT = 1;
   localparam int unsigned SYSC_RESET_REQ_BIT = 0;
   localparam int unsigned DBG_PORT_EN_BIT = 0;
   localparam int unsigned CAUSE_POR = 0;
   localparam int unsigned CAUSE_WDT = 1;
   localparam int unsigned CAUSE_EXT = 2;
   localparam int unsigned CAUSE_INT = 3;

   // Reset values.
   localparam logic [3:0] CAUSE_RST = 4'h1;
   localparam logic [2:0] BO_RST = 3'h0;

   // APB request and response groups.
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } rwsup_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rwsup_apb_rsp_t;

   // One bit per supply; core supply is bit 0.
   typedef struct packed {
      logic analog_supply;
      logic io_supply;
      logic core_supply;
   } rwsup_bo_t;

endpackage

// ---- core/rwsup_top.sv ----
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Interrupt timeout of 2^12/15/18/21 RC cycles.
// - Enabled watchdog expiry raises watchdog interrupt.
// - No restart in 512 RC: reset pin low eight.
// - Watchdog counts RC oscillator cycles, not system clock.
// - Software restarts in time, else controlled restart.
// - Any reset halts core, IO to defaults.
// - After reset release, fetch starts at 8000h.
// - Four sources: power-on, watchdog, pin, internal request.
// - Internal reset needs request bit plus debug enable.
// - Power-up pulls reset pin low, clears registers.
// - Hold power-on delay, then run unless pin low.
// - Readable flag shows the latest reset source.
// - Per-supply brownout monitor alerts the processor.
// - Separate enable bit for each brownout monitor.
module rwsup_top (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // APB slave.
   input wire rwsup_pkg::rwsup_apb_req_t apb_req,
   output rwsup_pkg::rwsup_apb_rsp_t apb_rsp,
   // Supply and oscillator inputs.
   input wire logic rc_clk_in,
   input wire logic core_supply_ok,
   input wire rwsup_pkg::rwsup_bo_t bo_low,
   // Open-drain reset pin.
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe_n,
   // Core control.
   output logic core_reset,
   output logic fetch_start,
   output logic [15:0] fetch_addr,
   // Interrupt requests.
   output logic wdt_irq,
   output logic brownout_irq
);
   import rwsup_pkg::*;

   typedef enum logic [1:0] {WD_COUNT, WD_GRACE, WD_RESET} rwsup_wd_st_t;
   typedef enum logic [1:0] {RS_POR, RS_HOLD, RS_RELEASE, RS_RUN} rwsup_rs_st_t;

   // Terminal count of the selected interrupt timeout.
   function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [1:0] sel);
      logic [WD_CNT_W:0] one;
      one = (WD_CNT_W+1)'(1);
      unique case (sel)
         2'h0: wd_limit = WD_CNT_W'((one << WD_EXP_0) - one);
         2'h1: wd_limit = WD_CNT_W'((one << WD_EXP_1) - one);
         2'h2: wd_limit = WD_CNT_W'((one << WD_EXP_2) - one);
         2'h3: wd_limit = WD_CNT_W'((one << WD_EXP_3) - one);
      endcase
   endfunction

   // True for every implemented register offset.
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == OFF_WD_CTRL) || (a == OFF_WD_RESTART) || (a == OFF_WD_STATUS) ||
                  (a == OFF_SYS_CTRL) || (a == OFF_DEBUG_FLAGS) || (a == OFF_RESET_CAUSE) ||
                  (a == OFF_BO_CTRL) || (a == OFF_BO_STATUS);
   endfunction

   logic rc_s1_q, rc_s2_q, rc_s3_q;
   logic pin_s1_q, pin_s2_q;
   logic rc_tick;
   logic wr_acc, rd_setup, restart;
   logic wd_en_q, wd_en_d;
   logic [1:0] wd_sel_q, wd_sel_d;
   logic wdt_flag_q, wdt_flag_d;
   logic reset_req_q, reset_req_d;
   logic dbg_en_q, dbg_en_d;
   logic [3:0] cause_q, cause_d;
   logic [2:0] bo_en_q, bo_en_d;
   logic [2:0] bo_flag_q, bo_flag_d;
   logic [31:0] prdata_q, prdata_d;
   logic slverr_q, slverr_d;
   rwsup_wd_st_t wd_st_q, wd_st_d;
   logic [WD_CNT_W-1:0] wd_cnt_q, wd_cnt_d;
   logic wd_irq_set, wd_drive;
   rwsup_rs_st_t rs_st_q, rs_st_d;
   logic [POR_CNT_W-1:0] por_cnt_q, por_cnt_d;
   logic [2:0] ext_cnt_q, ext_cnt_d;
   logic [3:0] cause_set;
   logic soft_clear, ext_seen;
   logic core_reset_q, core_reset_d;
   logic fetch_start_q, fetch_start_d;
   logic [15:0] fetch_addr_q, fetch_addr_d;

   // Input synchronisers; the second stage feeds the logic, and the RC third stage feeds only the edge detect.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rc_s1_q <= 1'b0;
         rc_s2_q <= 1'b0;
         rc_s3_q <= 1'b0;
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         rc_s1_q <= rc_clk_in;
         rc_s2_q <= rc_s1_q;
         rc_s3_q <= rc_s2_q;
         pin_s1_q <= reset_pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   // One system-clock tick per rising edge of the RC oscillator.
   assign rc_tick = rc_s2_q & ~rc_s3_q;

   // APB strobes; writes take effect at the access edge.
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
   assign restart = wr_acc && (apb_req.paddr == OFF_WD_RESTART);
   assign soft_clear = (rs_st_q == RS_RELEASE);

   // Register file next values, read data capture and sticky flags.
   always_comb begin
      wd_en_d = wd_en_q;
      wd_sel_d = wd_sel_q;
      wdt_flag_d = wdt_flag_q;
      reset_req_d = reset_req_q;
      dbg_en_d = dbg_en_q;
      cause_d = cause_q;
      bo_en_d = bo_en_q;
      bo_flag_d = bo_flag_q;
      prdata_d = prdata_q;
      slverr_d = slverr_q;
      if (wr_acc) begin
         unique case (apb_req.paddr)
            OFF_WD_CTRL: begin
               wd_en_d = apb_req.pwdata[WDC_EN_BIT];
               wd_sel_d = apb_req.pwdata[WDC_SEL_LSB +: 2];
            end
            OFF_WD_STATUS: wdt_flag_d = wdt_flag_q & ~apb_req.pwdata[WDS_IRQ_BIT];
            OFF_SYS_CTRL: reset_req_d = apb_req.pwdata[SYSC_RESET_REQ_BIT] & dbg_en_q;
            OFF_DEBUG_FLAGS: dbg_en_d = apb_req.pwdata[DBG_PORT_EN_BIT];
            OFF_RESET_CAUSE: cause_d = cause_q & ~apb_req.pwdata[3:0];
            OFF_BO_CTRL: bo_en_d = apb_req.pwdata[2:0];
            OFF_BO_STATUS: bo_flag_d = bo_flag_q & ~apb_req.pwdata[2:0];
            default: ;
         endcase
      end
      // Hardware sets win over software clears in the same cycle.
      if (wd_irq_set) begin
         wdt_flag_d = 1'b1;
      end
      bo_flag_d = bo_flag_d | (bo_en_q & bo_low);
      if (cause_set != 4'h0) begin
         cause_d = cause_set;
      end
      if (rs_st_q == RS_HOLD) begin
         reset_req_d = 1'b0;
      end
      if (soft_clear) begin
         wd_en_d = 1'b0;
         wd_sel_d = 2'h0;
         wdt_flag_d = 1'b0;
         reset_req_d = 1'b0;
      end
      if (rd_setup) begin
         slverr_d = ~is_mapped(apb_req.paddr);
         prdata_d = 32'h0000_0000;
         unique case (apb_req.paddr)
            OFF_WD_CTRL: begin
               prdata_d[WDC_EN_BIT] = wd_en_q;
               prdata_d[WDC_SEL_LSB +: 2] = wd_sel_q;
            end
            OFF_WD_STATUS: begin
               prdata_d[WDS_IRQ_BIT] = wdt_flag_q;
               prdata_d[WDS_GRACE_BIT] = (wd_st_q != WD_COUNT);
            end
            OFF_SYS_CTRL: prdata_d[SYSC_RESET_REQ_BIT] = reset_req_q;
            OFF_DEBUG_FLAGS: prdata_d[DBG_PORT_EN_BIT] = dbg_en_q;
            OFF_RESET_CAUSE: prdata_d[3:0] = cause_q;
            OFF_BO_CTRL: prdata_d[2:0] = bo_en_q;
            OFF_BO_STATUS: prdata_d[2:0] = bo_flag_q;
            default: ;
         endcase
      end else if (apb_req.psel & ~apb_req.penable) begin
         slverr_d = ~is_mapped(apb_req.paddr);
      end
   end

   // Register file storage.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wd_en_q <= 1'b0;
         wd_sel_q <= 2'h0;
         wdt_flag_q <= 1'b0;
         reset_req_q <= 1'b0;
         dbg_en_q <= 1'b0;
         cause_q <= CAUSE_RST;
         bo_en_q <= BO_RST;
         bo_flag_q <= BO_RST;
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else begin
         wd_en_q <= wd_en_d;
         wd_sel_q <= wd_sel_d;
         wdt_flag_q <= wdt_flag_d;
         reset_req_q <= reset_req_d;
         dbg_en_q <= dbg_en_d;
         cause_q <= cause_d;
         bo_en_q <= bo_en_d;
         bo_flag_q <= bo_flag_d;
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   // Watchdog: interrupt timeout, grace window, then reset pulse.
   always_comb begin
      wd_st_d = wd_st_q;
      wd_cnt_d = wd_cnt_q;
      wd_irq_set = 1'b0;
      unique case (wd_st_q)
         WD_COUNT: begin
            if (!wd_en_q || restart) begin
               wd_cnt_d = '0;
            end else if (rc_tick) begin
               if (wd_cnt_q == wd_limit(wd_sel_q)) begin
                  wd_cnt_d = '0;
                  wd_st_d = WD_GRACE;
                  wd_irq_set = 1'b1;
               end else begin
                  wd_cnt_d = wd_cnt_q + 1'b1;
               end
            end
         end
         WD_GRACE: begin
            if (!wd_en_q || restart) begin
               wd_cnt_d = '0;
               wd_st_d = WD_COUNT;
            end else if (rc_tick) begin
               if (wd_cnt_q == WD_GRACE_LAST) begin
                  wd_cnt_d = '0;
                  wd_st_d = WD_RESET;
               end else begin
                  wd_cnt_d = wd_cnt_q + 1'b1;
               end
            end
         end
         WD_RESET: begin
            if (rc_tick) begin
               if (wd_cnt_q == WD_RST_LAST) begin
                  wd_cnt_d = '0;
                  wd_st_d = WD_COUNT;
               end else begin
                  wd_cnt_d = wd_cnt_q + 1'b1;
               end
            end
         end
         default: begin
            wd_cnt_d = '0;
            wd_st_d = WD_COUNT;
         end
      endcase
   end

   // Watchdog state storage.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wd_st_q <= WD_COUNT;
         wd_cnt_q <= '0;
      end else begin
         wd_st_q <= wd_st_d;
         wd_cnt_q <= wd_cnt_d;
      end
   end

   assign wd_drive = (wd_st_q == WD_RESET);
   assign ext_seen = ~pin_s2_q && (ext_cnt_q == EXT_LAST);

   // Reset sequencer: power-on delay, source capture, pin release, restart.
   always_comb begin
      rs_st_d = rs_st_q;
      por_cnt_d = por_cnt_q;
      ext_cnt_d = '0;
      cause_set = 4'h0;
      fetch_start_d = 1'b0;
      fetch_addr_d = fetch_addr_q;
      unique case (rs_st_q)
         RS_POR: begin
            if (!core_supply_ok) begin
               por_cnt_d = '0;
            end else if (por_cnt_q == POR_LAST) begin
               por_cnt_d = '0;
               rs_st_d = RS_RELEASE;
            end else begin
               por_cnt_d = por_cnt_q + 1'b1;
            end
         end
         RS_RUN: begin
            if (!pin_s2_q && ext_cnt_q != EXT_LAST) begin
               ext_cnt_d = ext_cnt_q + 1'b1;
            end
            if (!core_supply_ok) begin
               rs_st_d = RS_POR;
               cause_set[CAUSE_POR] = 1'b1;
            end else if (wd_drive) begin
               rs_st_d = RS_HOLD;
               cause_set[CAUSE_WDT] = 1'b1;
            end else if (ext_seen) begin
               rs_st_d = RS_HOLD;
               cause_set[CAUSE_EXT] = 1'b1;
            end else if (reset_req_q) begin
               rs_st_d = RS_HOLD;
               cause_set[CAUSE_INT] = 1'b1;
            end
         end
         RS_HOLD: begin
            if (!core_supply_ok) begin
               rs_st_d = RS_POR;
               cause_set[CAUSE_POR] = 1'b1;
            end else if (!wd_drive && pin_s2_q) begin
               rs_st_d = RS_RELEASE;
            end
         end
         RS_RELEASE: begin
            if (!core_supply_ok) begin
               rs_st_d = RS_POR;
               cause_set[CAUSE_POR] = 1'b1;
            end else if (pin_s2_q) begin
               rs_st_d = RS_RUN;
               fetch_start_d = 1'b1;
               fetch_addr_d = RESET_VECTOR;
            end
         end
      endcase
      core_reset_d = (rs_st_d != RS_RUN);
   end

   // Reset sequencer storage.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rs_st_q <= RS_POR;
         por_cnt_q <= '0;
         ext_cnt_q <= '0;
         core_reset_q <= 1'b1;
         fetch_start_q <= 1'b0;
         fetch_addr_q <= RESET_VECTOR;
      end else begin
         rs_st_q <= rs_st_d;
         por_cnt_q <= por_cnt_d;
         ext_cnt_q <= ext_cnt_d;
         core_reset_q <= core_reset_d;
         fetch_start_q <= fetch_start_d;
         fetch_addr_q <= fetch_addr_d;
      end
   end

   // Outputs; the pin is open drain, so only its enable moves.
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe_n = ~((rs_st_q == RS_POR) | wd_drive);
   assign core_reset = core_reset_q;
   assign fetch_start = fetch_start_q;
   assign fetch_addr = fetch_addr_q;
   assign wdt_irq = wdt_flag_q;
   assign brownout_irq = |(bo_flag_q & bo_en_q);
   assign apb_rsp = '{prdata: prdata_q, pready: 1'b1, pslverr: slverr_q};

   // Checks on the watchdog path.
   wd_timeout_a: assert property (@(posedge sys_clk) disable iff (rst)
      (wd_st_q == WD_COUNT && wd_en_q && !restart && !soft_clear && rc_tick &&
       wd_cnt_q == wd_limit(wd_sel_q)) |=> (wd_st_q == WD_GRACE && wd_cnt_q == '0))
      else $error("watchdog did not enter grace at timeout");
   wd_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
      (wd_st_q == WD_GRACE && $past(wd_st_q) == WD_COUNT) |-> (wdt_irq || $past(soft_clear)))
      else $error("watchdog interrupt missing after timeout");
   wd_grace_a: assert property (@(posedge sys_clk) disable iff (rst)
      (wd_st_q == WD_GRACE && wd_en_q && !restart && rc_tick && wd_cnt_q == WD_GRACE_LAST)
      |=> (!reset_pin_oe_n && wd_st_q == WD_RESET))
      else $error("reset pin not driven after grace window");
   wd_rcclk_a: assert property (@(posedge sys_clk) disable iff (rst)
      (!rc_tick && (wd_st_q == WD_RESET || (wd_en_q && !restart))) |=> $stable(wd_cnt_q))
      else $error("watchdog counter moved without an RC edge");
   wd_restart_a: assert property (@(posedge sys_clk) disable iff (rst)
      (restart && wd_st_q != WD_RESET) |=> (wd_cnt_q == '0 && wd_st_q == WD_COUNT))
      else $error("restart write did not reload watchdog");
   // Checks on the reset sequencer and the brownout flag.
   rs_halt_a: assert property (@(posedge sys_clk) disable iff (rst)
      (rs_st_q != RS_RUN) |-> (core_reset && !fetch_start))
      else $error("core not held while reset active");
   rs_vector_a: assert property (@(posedge sys_clk) disable iff (rst)
      fetch_start |-> (fetch_addr == RESET_VECTOR && $past(rs_st_q) == RS_RELEASE && !core_reset))
      else $error("restart not at reset vector");
   rs_internal_a: assert property (@(posedge sys_clk) disable iff (rst)
      (rs_st_q == RS_RUN && core_supply_ok && !wd_drive && !ext_seen && reset_req_q)
      |=> (rs_st_q == RS_HOLD && cause_q == 4'h8))
      else $error("internal reset request not taken");
   rs_por_a: assert property (@(posedge sys_clk) disable iff (rst)
      (rs_st_q == RS_POR) |-> (!reset_pin_oe_n && core_reset))
      else $error("pin not pulled low during power-on");
   rs_extpin_a: assert property (@(posedge sys_clk) disable iff (rst)
      (rs_st_q == RS_RUN && core_supply_ok && !wd_drive && !pin_s2_q && ext_cnt_q == EXT_LAST)
      |=> (rs_st_q == RS_HOLD && cause_q[CAUSE_EXT]))
      else $error("external reset not recognized after four lows");
   bo_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
      (bo_en_q[0] && bo_low.core_supply) |=> (bo_flag_q[0] ##1 (bo_flag_q[0] || $past(wr_acc))))
      else $error("brownout flag not latched");

endmodule

// ---- tb/rwsup_board.sv ----
`timescale 1ns/1ps
// Board side of the reset pin plus the free-running RC oscillator.
module rwsup_board (
   // Clock.
   input wire logic sys_clk,
   // Pin enable from the block.
   input wire logic reset_pin_oe_n,
   // Pin level and oscillator.
   output wire logic reset_pin_in,
   output logic rc_clk_in
);
   logic board_low = 1'b0;

   // Oscillator at 200 ns, phase unrelated to the system clock.
   initial begin
      rc_clk_in = 1'b0;
      #37;
      forever #100 rc_clk_in = ~rc_clk_in;
   end

   // Open-drain wire with a pull-up: low when either party pulls.
   assign reset_pin_in = ~(board_low | ~reset_pin_oe_n);

   // Pulls the pin low for n cycles; n below four only on purpose.
   task pull_pin(input int n);
      @(posedge sys_clk);
      board_low <= 1'b1;
      repeat (n) @(posedge sys_clk);
      board_low <= 1'b0;
   endtask
endmodule

// ---- tb/tb_reset_watchdog_supervisor.sv ----
`timescale 1ns/1ps
// Register-level test of reset sources, watchdog and brownout flags.
module tb_reset_watchdog_supervisor;
   import rwsup_pkg::*;
   logic sys_clk;
   logic rst;
   rwsup_apb_req_t apb_req;
   rwsup_apb_rsp_t apb_rsp;
   logic core_supply_ok;
   rwsup_bo_t bo_low;
   logic rc_clk_in, reset_pin_in, reset_pin_oe_n, core_reset, fetch_start, wdt_irq, brownout_irq;
   logic [15:0] fetch_addr;
   logic reset_pin_out;
   int num_errors = 0;
   int n_tests = 0;
   int rc_ticks = 0;
   int n, t0;

   rwsup_top DUT (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .rc_clk_in(rc_clk_in), .core_supply_ok(core_supply_ok), .bo_low(bo_low),
      .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
      .core_reset(core_reset), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
      .wdt_irq(wdt_irq), .brownout_irq(brownout_irq));
   rwsup_board board (.sys_clk(sys_clk), .reset_pin_oe_n(reset_pin_oe_n),
      .reset_pin_in(reset_pin_in), .rc_clk_in(rc_clk_in));

   // System clock of 50 ns.
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Counts oscillator edges as the watchdog time base.
   always @(posedge rc_clk_in) rc_ticks <= rc_ticks + 1;

   task finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task check_rng(input string name, input int lo, input int hi, input int got);
      n_tests++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   // One APB transfer; waits for pready under a bound.
   task apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                 output logic err);
      int k;
      k = 0;
      @(posedge sys_clk);
      apb_req.psel <= 1'b1;
      apb_req.pwrite <= wr;
      apb_req.paddr <= a;
      apb_req.pwdata <= wd;
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (apb_rsp.pready !== 1'b1 && k < 50);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      if (k >= 50) begin
         num_errors++;
         $display("ERROR apb pready expected 1 seen timeout");
         finish_test();
      end
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb_xfer(1'b1, a, d, rd, err);
   endtask

   task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb_xfer(1'b0, a, 32'h0, rd, err);
      check(name, exp, rd);
   endtask

   // Waits up to max cycles for a signal level; cnt is -1 when it never came.
   task wait_for(input int sel, input logic val, input int max, output int cnt, input bit fatal);
      logic s;
      cnt = -1;
      for (int i = 0; i < max && cnt < 0; i++) begin
         @(negedge sys_clk);
         case (sel)
            0: s = fetch_start;
            1: s = core_reset;
            2: s = wdt_irq;
            default: s = reset_pin_oe_n;
         endcase
         if (s === val) cnt = i;
      end
      if (cnt < 0 && fatal) begin
         num_errors++;
         $display("ERROR wait %0d expected %b seen timeout", sel, val);
         finish_test();
      end
   endtask

   initial begin
      logic [31:0] rd;
      logic err;
      rst = 1'b1;
      apb_req = '0;
      core_supply_ok = 1'b1;
      bo_low = '0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      check("core_reset at power-up", 32'h1, 32'(core_reset));
      check("pin oe_n at power-up", 32'h0, 32'(reset_pin_oe_n));
      check("pin out level", 32'h0, 32'(reset_pin_out));
      rd_chk("bo status reset", OFF_BO_STATUS, 32'(BO_RST));
      wait_for(0, 1'b1, 2100, n, 1'b1);
      check_rng("power-on delay", 1990, 2010, n);
      check("fetch addr", 32'(RESET_VECTOR), 32'(fetch_addr));
      check("core_reset released", 32'h0, 32'(core_reset));
      rd_chk("cause por", OFF_RESET_CAUSE, 32'h1);
      apb_xfer(1'b0, 12'h040, 32'h0, rd, err);
      check("unmapped err", 32'h1, 32'(err));
      check("unmapped data", 32'h0, rd);
      $display("TEST power-on done");

      // Each supply flag only with its own enable, sticky until cleared.
      for (int i = 0; i < 3; i++) begin
         wr(OFF_BO_CTRL, 32'(1 << i));
         @(posedge sys_clk);
         bo_low <= 3'h7;
         repeat (3) @(posedge sys_clk);
         bo_low <= 3'h0;
         rd_chk("bo flag", OFF_BO_STATUS, 32'(1 << i));
         check("bo irq", 32'h1, 32'(brownout_irq));
         wr(OFF_BO_CTRL, 32'h0);
         @(negedge sys_clk);
         check("bo irq masked", 32'h0, 32'(brownout_irq));
         wr(OFF_BO_STATUS, 32'h7);
         rd_chk("bo cleared", OFF_BO_STATUS, 32'h0);
      end
      $display("TEST brownout done");

      board.pull_pin(3);
      wait_for(1, 1'b1, 15, n, 1'b0);
      check("short pin pulse ignored", 32'h1, 32'(n < 0));
      board.pull_pin(6);
      wait_for(1, 1'b1, 20, n, 1'b1);
      wait_for(0, 1'b1, 50, n, 1'b1);
      rd_chk("cause external", OFF_RESET_CAUSE, 32'h4);
      $display("TEST external reset done");

      wr(OFF_SYS_CTRL, 32'h1);
      wait_for(1, 1'b1, 10, n, 1'b0);
      check("request without debug", 32'h1, 32'(n < 0));
      wr(OFF_DEBUG_FLAGS, 32'h1);
      wr(OFF_SYS_CTRL, 32'h1);
      wait_for(1, 1'b1, 10, n, 1'b1);
      check("internal no pin drive", 32'h1, 32'(reset_pin_oe_n));
      wait_for(0, 1'b1, 50, n, 1'b1);
      rd_chk("cause internal", OFF_RESET_CAUSE, 32'h8);
      rd_chk("debug kept", OFF_DEBUG_FLAGS, 32'h1);
      $display("TEST internal reset done");

      for (int s = 0; s < 4; s++) begin
         wr(OFF_WD_CTRL, 32'(s << WDC_SEL_LSB));
         rd_chk("wd select", OFF_WD_CTRL, 32'(s << WDC_SEL_LSB));
      end
      wr(OFF_WD_CTRL, 32'h1);
      t0 = rc_ticks;
      wait_for(2, 1'b1, 12000, n, 1'b0);
      check("no irq before timeout", 32'h1, 32'(n < 0));
      wr(OFF_WD_RESTART, 32'h0);
      t0 = rc_ticks;
      wait_for(2, 1'b1, 17000, n, 1'b1);
      check_rng("irq ticks", 4095, 4098, rc_ticks - t0);
      rd_chk("wd status irq", OFF_WD_STATUS, 32'h3);
      t0 = rc_ticks;
      wr(OFF_WD_STATUS, 32'h1);
      rd_chk("wd flag cleared", OFF_WD_STATUS, 32'h2);
      check("wd irq cleared", 32'h0, 32'(wdt_irq));
      wait_for(3, 1'b0, 2200, n, 1'b1);
      check_rng("grace ticks", 510, 514, rc_ticks - t0);
      t0 = rc_ticks;
      wait_for(3, 1'b1, 60, n, 1'b1);
      check_rng("pin pulse ticks", 7, 9, rc_ticks - t0);
      check("core held", 32'h1, 32'(core_reset));
      wait_for(0, 1'b1, 50, n, 1'b1);
      rd_chk("cause watchdog", OFF_RESET_CAUSE, 32'h2);
      rd_chk("wd ctrl cleared", OFF_WD_CTRL, 32'h0);
      $display("TEST watchdog done");

      // Supply drop restarts the power-on delay; start waits while the board holds the pin.
      @(posedge sys_clk);
      core_supply_ok <= 1'b0;
      wait_for(3, 1'b0, 5, n, 1'b1);
      check("core_reset on drop", 32'h1, 32'(core_reset));
      @(posedge sys_clk);
      core_supply_ok <= 1'b1;
      board.pull_pin(2100);
      check("start waits for pin", 32'h1, 32'(core_reset));
      wait_for(0, 1'b1, 50, n, 1'b1);
      rd_chk("cause por again", OFF_RESET_CAUSE, 32'h1);
      $display("TEST supply drop done");
      finish_test();
   end
endmodule
